// file: src/crcau_pkg.sv
/*
 * Package for the byte-wide CRC unit with automatic flash scan.
 * Holds register offsets, field positions, reset values, polynomials,
 * the scan state type and the register-bus request struct.
 * Assumes a byte-wide special-function-register bus.
 */
//
// Contract
// - A feed-byte write folds the byte into the existing result.
// - Result port accesses hit the result byte chosen by the pointer.
// - Control-register write with auto enable set starts a flash scan.
// - Completion flag reads 0 during a scan, 1 otherwise.
// - Processor execution is stalled for the whole automatic scan.
// - First scanned address is start sector times 1024.
// - Last scanned sector starts at (start plus count) times 1024.
// - Upper two bits of the sector-count register read zero.
// - Bit-reverse register reads back the written byte mirrored.
// - Select 0 uses 32-bit 0x04C11DB7; select 1 uses 16-bit 0x1021.
// - Preset trigger loads all zeros or all ones per value select.
// - Pointer advances per result access; 16-bit mode wraps 10/11 low.
// - Result holds until preset, overwritten, or more bytes fed.
// - Start-sector field lives in bits 5:0 of the auto control register.
package crcau_pkg;
	localparam logic [7:0]  CRCAU_OFS_RESULT  = 8'h91;
	localparam logic [7:0]  CRCAU_OFS_CONTROL = 8'h92;
	localparam logic [7:0]  CRCAU_OFS_FEED    = 8'h93;
	localparam logic [7:0]  CRCAU_OFS_FLIP    = 8'h95;
	localparam logic [7:0]  CRCAU_OFS_AUTO    = 8'h96;
	localparam logic [7:0]  CRCAU_OFS_COUNT   = 8'h97;
	localparam int          CRCAU_BIT_SEL     = 4;
	localparam int          CRCAU_BIT_INIT    = 3;
	localparam int          CRCAU_BIT_VAL     = 2;
	localparam int          CRCAU_BIT_AUTO_CALC_ENABLE  = 7;
	localparam int          CRCAU_BIT_DONE    = 6;
	localparam logic [31:0] CRCAU_POLY32      = 32'h04C11DB7;
	localparam logic [15:0] CRCAU_POLY16      = 16'h1021;
	localparam logic [31:0] CRCAU_PRESET_ZERO = 32'h00000000;
	localparam logic [31:0] CRCAU_PRESET_ONES = 32'hFFFFFFFF;
	localparam logic [7:0]  CRCAU_RST_BYTE    = 8'h00;
	localparam logic [31:0] CRCAU_RST_RESULT  = 32'h00000000;
	localparam int          CRCAU_SECTOR_LOG2 = 10;
	localparam int          CRCAU_ADDR_W      = 16;

	typedef enum logic [1:0] {
		CRCAU_IDLE  = 2'b00,
		CRCAU_FETCH = 2'b01,
		CRCAU_FOLD  = 2'b11
	} crcau_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} crcau_sfr_req_t;
endpackage

// file: src/crcau_fold.sv
/*
 * One-byte CRC fold: combines an 8-bit input into a running CRC, MSB
 * first, for either the 32-bit or the 16-bit polynomial.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
module crcau_fold
	import crcau_pkg::*;
(
	input  wire logic        sel16,     // 1 selects the 16-bit polynomial
	input  wire logic [31:0] crc_in,    // current result
	input  wire logic [7:0]  data,      // byte to fold in
	output logic      [31:0] crc_out    // result after the byte
);
	always_comb begin
		logic [31:0] c;
		logic [15:0] h;
		c = crc_in;
		h = crc_in[15:0];
		for (int i = 7; i >= 0; i--) begin
			if (c[31] ^ data[i]) begin
				c = {c[30:0], 1'b0} ^ CRCAU_POLY32;
			end else begin
				c = {c[30:0], 1'b0};
			end
			if (h[15] ^ data[i]) begin
				h = {h[14:0], 1'b0} ^ CRCAU_POLY16;
			end else begin
				h = {h[14:0], 1'b0};
			end
		end
		// The upper half is kept zero in 16-bit mode.
		crc_out = sel16 ? {16'h0000, h} : c;
	end
endmodule
`default_nettype wire

// file: src/crcau_top.sv
/*
 * CRC unit with automatic flash scan, on the special-function-register
 * bus. Software feeds bytes, reads the result a byte at a time, and can
 * start a hardware scan over 1024-byte flash sectors.
 * Assumes a single-cycle SFR bus and a flash port that returns data one
 * cycle after the read strobe. The core honours cpu_stall.
 */
`timescale 1ns/1ps
`default_nettype none
module crcau_top
	import crcau_pkg::*;
(
	input  wire logic                    clk_sys,     // 100 MHz clock
	input  wire logic                    reset_n,     // async reset, low
	input  wire crcau_sfr_req_t          sfr_req,     // SFR access
	output logic      [7:0]              sfr_rdata,   // SFR read data
	output logic                         cpu_stall,   // halts execution
	output logic                         flash_rd,    // flash read strobe
	output logic      [CRCAU_ADDR_W-1:0] flash_addr,  // flash byte address
	input  wire logic [7:0]              flash_rdata  // flash data
);
	logic [31:0]             result_r, result_nxt;
	logic [1:0]              ptr_r, ptr_nxt;
	logic                    sel_r, sel_nxt;
	logic                    val_r, val_nxt;
	logic [7:0]              feed_r, feed_nxt;
	logic [7:0]              flip_r, flip_nxt;
	logic                    auto_calc_enable_r, auto_calc_enable_nxt;
	logic [5:0]              start_r, start_nxt;
	logic [5:0]              count_r, count_nxt;
	crcau_state_t            state_r, state_nxt;
	logic [CRCAU_ADDR_W-1:0] addr_r, addr_nxt;
	logic [CRCAU_ADDR_W-1:0] last_addr;
	logic [7:0]              fold_byte;
	logic [31:0]             folded;
	logic [1:0]              eff_ptr;
	logic [7:0]              ptr_byte;
	logic                    wr, rd;

	assign wr = sfr_req.wr && (state_r == CRCAU_IDLE);
	assign rd = sfr_req.rd && (state_r == CRCAU_IDLE);

	////////////////////////////////////////////////////////////////////
	// In 16-bit mode pointer values 10 and 11 both alias the low byte.
	assign eff_ptr  = (sel_r && ptr_r[1]) ? 2'b00 : ptr_r;
	assign ptr_byte = result_r[eff_ptr*8 +: 8];

	// The last byte is the final byte of sector (start+count).
	assign last_addr = CRCAU_ADDR_W'({({1'b0, start_r} + {1'b0, count_r}),
		{CRCAU_SECTOR_LOG2{1'b1}}});

	assign fold_byte = (state_r == CRCAU_FOLD) ? flash_rdata
		: sfr_req.wdata;

	crcau_fold crcau_fold_inst (
		.sel16   (sel_r),
		.crc_in  (result_r),
		.data    (fold_byte),
		.crc_out (folded)
	);

	////////////////////////////////////////////////////////////////////
	always_comb begin
		result_nxt = result_r;
		ptr_nxt    = ptr_r;
		sel_nxt    = sel_r;
		val_nxt    = val_r;
		feed_nxt   = feed_r;
		flip_nxt   = flip_r;
		auto_calc_enable_nxt = auto_calc_enable_r;
		start_nxt  = start_r;
		count_nxt  = count_r;
		state_nxt  = state_r;
		addr_nxt   = addr_r;
		if (wr) begin
			case (sfr_req.addr)
			CRCAU_OFS_RESULT: begin
				result_nxt[eff_ptr*8 +: 8] = sfr_req.wdata;
				ptr_nxt = ptr_r + 2'b01;
			end
			CRCAU_OFS_CONTROL: begin
				sel_nxt    = sfr_req.wdata[CRCAU_BIT_SEL];
				val_nxt    = sfr_req.wdata[CRCAU_BIT_VAL];
				ptr_nxt    = sfr_req.wdata[1:0];
				if (sfr_req.wdata[CRCAU_BIT_INIT]) begin
					result_nxt = sfr_req.wdata[CRCAU_BIT_VAL]
						? CRCAU_PRESET_ONES : CRCAU_PRESET_ZERO;
				end
				if (auto_calc_enable_r) begin
					state_nxt = CRCAU_FETCH;
					addr_nxt  = CRCAU_ADDR_W'({start_r,
						{CRCAU_SECTOR_LOG2{1'b0}}});
				end
			end
			CRCAU_OFS_FEED: begin
				feed_nxt   = sfr_req.wdata;
				result_nxt = folded;
			end
			CRCAU_OFS_FLIP: begin
				for (int i = 0; i < 8; i++) begin
					flip_nxt[7-i] = sfr_req.wdata[i];
				end
			end
			CRCAU_OFS_AUTO: begin
				auto_calc_enable_nxt = sfr_req.wdata[CRCAU_BIT_AUTO_CALC_ENABLE];
				start_nxt  = sfr_req.wdata[5:0];
			end
			CRCAU_OFS_COUNT: begin
				count_nxt = sfr_req.wdata[5:0];
			end
			default: begin
			end
			endcase
		end else if (rd && sfr_req.addr == CRCAU_OFS_RESULT) begin
			ptr_nxt = ptr_r + 2'b01;
		end
		case (state_r)
		CRCAU_IDLE: begin
		end
		CRCAU_FETCH: begin
			state_nxt = CRCAU_FOLD;
		end
		CRCAU_FOLD: begin
			result_nxt = folded;
			if (addr_r == last_addr) begin
				state_nxt = CRCAU_IDLE;
			end else begin
				addr_nxt  = addr_r + 1'b1;
				state_nxt = CRCAU_FETCH;
			end
		end
		default: begin
			state_nxt = CRCAU_IDLE;
		end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			result_r <= CRCAU_RST_RESULT;
			ptr_r    <= 2'b00;
			sel_r    <= 1'b0;
			val_r    <= 1'b0;
			feed_r   <= CRCAU_RST_BYTE;
			flip_r   <= CRCAU_RST_BYTE;
			auto_calc_enable_r <= 1'b0;
			start_r  <= 6'h00;
			count_r  <= 6'h00;
			state_r  <= CRCAU_IDLE;
			addr_r   <= '0;
		end else begin
			result_r <= result_nxt;
			ptr_r    <= ptr_nxt;
			sel_r    <= sel_nxt;
			val_r    <= val_nxt;
			feed_r   <= feed_nxt;
			flip_r   <= flip_nxt;
			auto_calc_enable_r <= auto_calc_enable_nxt;
			start_r  <= start_nxt;
			count_r  <= count_nxt;
			state_r  <= state_nxt;
			addr_r   <= addr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Stall covers every scan cycle so firmware never sees the flag low.
	assign cpu_stall  = (state_r != CRCAU_IDLE);
	assign flash_rd   = (state_r == CRCAU_FETCH);
	assign flash_addr = addr_r;

	always_comb begin
		case (sfr_req.addr)
		CRCAU_OFS_RESULT:  sfr_rdata = ptr_byte;
		// Bits 7:5 are unused and the init bit self-clears, so both read 0.
		CRCAU_OFS_CONTROL: sfr_rdata = {3'h0, sel_r, 1'b0, val_r,
			ptr_r};
		CRCAU_OFS_FEED:    sfr_rdata = feed_r;
		CRCAU_OFS_FLIP:    sfr_rdata = flip_r;
		CRCAU_OFS_AUTO:    sfr_rdata = {auto_calc_enable_r,
			state_r == CRCAU_IDLE, start_r};
		CRCAU_OFS_COUNT:   sfr_rdata = {2'b00, count_r};
		default:           sfr_rdata = 8'h00;
		endcase
	end
endmodule
`default_nettype wire

// file: verification/crcau_chk.sv
/* Assertions on the ports of crcau_top.
   Assumes single-cycle register-bus requests on the system clock. */
`timescale 1ns/1ps
`default_nettype none
module crcau_chk
	import crcau_pkg::*;
(
	input wire logic                    clk_sys,     // clock
	input wire logic                    reset_n,     // reset
	input wire crcau_sfr_req_t          sfr_req,     // request
	input wire logic [7:0]              sfr_rdata,   // read data
	input wire logic                    cpu_stall,   // stall
	input wire logic                    flash_rd,    // strobe
	input wire logic [CRCAU_ADDR_W-1:0] flash_addr,  // address
	input wire logic [7:0]              flash_rdata  // data
);
	logic [7:0] a;
	logic       go;
	logic [7:0] auto_r;
	logic [7:0] auto_nxt;
	logic [7:0] flip_exp;
	assign a = sfr_req.addr;
	// Mirror of the written byte, kept apart from the design's own loop.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			flip_exp[i] = sfr_req.wdata[7 - i];
		end
	end
	assign go = sfr_req.wr && !cpu_stall;
	// Shadow of the auto byte; the design ignores writes to it while stalled.
	always_comb auto_nxt = (go && a == CRCAU_OFS_AUTO) ?
		sfr_req.wdata : auto_r;
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n) auto_r <= 8'h00;
		else auto_r <= auto_nxt;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	chk_flip_mirror: assert property (
		$past(go) && $past(a) == CRCAU_OFS_FLIP && a == CRCAU_OFS_FLIP
		|-> sfr_rdata == $past(flip_exp)) else $error("flip");
	chk_count_upper: assert property (
		a == CRCAU_OFS_COUNT |-> sfr_rdata[7:6] == 2'b00) else $error("cnt");
	chk_done_flag: assert property (
		a == CRCAU_OFS_AUTO |-> sfr_rdata[6] == !cpu_stall) else $error("done");
	chk_scan_start: assert property (
		go && a == CRCAU_OFS_CONTROL && auto_r[7] |=> cpu_stall && flash_rd
		&& flash_addr == {auto_r[5:0], 10'h000}) else $error("start");
	chk_no_start: assert property (
		go && a == CRCAU_OFS_CONTROL && !auto_r[7] |=> !cpu_stall)
		else $error("spurious scan");
	chk_fetch_stall: assert property (
		flash_rd |-> cpu_stall ##1 !flash_rd && cpu_stall) else $error("fetch");
	chk_fetch_step: assert property (
		flash_rd ##2 flash_rd |-> flash_addr == $past(flash_addr, 2) + 16'h0001)
		else $error("order");
	chk_scan_end: assert property (
		$fell(cpu_stall) |-> $past(flash_addr[9:0], 2) == 10'h3FF)
		else $error("end");
endmodule
bind crcau_top crcau_chk crcau_chk_inst (.clk_sys(clk_sys),
	.reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
	.cpu_stall(cpu_stall), .flash_rd(flash_rd), .flash_addr(flash_addr),
	.flash_rdata(flash_rdata));
`default_nettype wire

// file: verification/crcau_flash_model.sv
/* Flash behind the fetch port.
   Assumes one strobe per byte; data is valid the next cycle only. */
`timescale 1ns/1ps
`default_nettype none
module crcau_flash_model (
	input  wire logic [15:0] flash_addr,  // byte address
	input  wire logic        clk_sys,     // clock
	input  wire logic        flash_rd,    // strobe
	output var logic  [7:0]  flash_rdata  // data
);
	initial flash_rdata = 8'h00;
	// Toggling outside the valid cycle exposes a late sample.
	always @(posedge clk_sys)
		flash_rdata <= flash_rd ?
			flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h5A : ~flash_rdata;
endmodule
`default_nettype wire

// file: verification/crcau_top_test.sv
/* Self-checking bench for crcau_top with a flash model.
   Assumes a single-cycle register bus with same-cycle read data. */
`timescale 1ns/1ps
`default_nettype none
module crcau_top_test
	import crcau_pkg::*;
;
	logic           clk_sys = 1'b0;
	logic           reset_n = 1'b0;
	crcau_sfr_req_t sfr_req = '0;
	logic [7:0]     sfr_rdata;
	logic           cpu_stall;
	logic           flash_rd;
	logic [15:0]    flash_addr;
	logic [7:0]     flash_rdata;
	int             num_errors = 0;
	int             n_compared = 0;
	int             cycles = 0;
	logic [7:0]     q;
	logic [31:0]    crc;
	always #5 clk_sys = ~clk_sys;
	crcau_top crcau_top_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .cpu_stall(cpu_stall),
		.flash_rd(flash_rd), .flash_addr(flash_addr),
		.flash_rdata(flash_rdata));
	crcau_flash_model crcau_flash_model_inst (.clk_sys(clk_sys),
		.flash_rd(flash_rd), .flash_addr(flash_addr),
		.flash_rdata(flash_rdata));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// Requests stay up back to back; idle drops them.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
		#1 q = sfr_rdata;
	endtask
	task automatic idle();
		@(negedge clk_sys);
		sfr_req = '0;
	endtask
	function automatic logic [31:0] fold(input logic s, input logic [31:0] c,
		input logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			if (s)
				c = {16'h0000, c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 32'h1021 : 0);
			else
				c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRCAU_POLY32 : 0);
		return c;
	endfunction
	task automatic rd_res(input logic s);
		for (int p = 0; p < 4; p++) begin
			acc(0, CRCAU_OFS_RESULT, 8'h00);
			check(q, crc[8 * ((s && p > 1) ? 0 : p) +: 8]);
		end
	endtask
	task automatic t_regs();
		acc(0, CRCAU_OFS_AUTO, 8'h00);
		check(q, 8'h40);
		acc(1, CRCAU_OFS_COUNT, 8'hFF);
		acc(0, CRCAU_OFS_COUNT, 8'h00);
		check(q, 8'h3F);
		acc(1, CRCAU_OFS_FLIP, 8'hC0);
		acc(0, CRCAU_OFS_FLIP, 8'h00);
		check(q, 8'h03);
		acc(1, CRCAU_OFS_FLIP, 8'h05);
		acc(0, CRCAU_OFS_FLIP, 8'h00);
		check(q, 8'hA0);
		$display("regs done");
	endtask
	task automatic t_feed();
		for (int m = 0; m < 4; m++) begin
			crc = m[0] ? CRCAU_PRESET_ONES : CRCAU_PRESET_ZERO;
			acc(1, CRCAU_OFS_CONTROL, {3'b000, m[1], 1'b1, m[0], 2'b00});
			for (int b = 0; b < 3; b++) begin
				acc(1, CRCAU_OFS_FEED, 8'(8'h31 + b));
				crc = fold(m[1], crc, 8'(8'h31 + b));
			end
			rd_res(m[1]);
		end
		acc(1, CRCAU_OFS_CONTROL, 8'h00);
		for (int p = 1; p < 5; p++)
			acc(1, CRCAU_OFS_RESULT, 8'(8'h11 * p));
		acc(1, CRCAU_OFS_FEED, 8'h5A);
		crc = fold(1'b0, 32'h44332211, 8'h5A);
		rd_res(1'b0);
		$display("feed done");
	endtask
	task automatic t_scan();
		int n;
		crc = CRCAU_PRESET_ONES;
		for (int a = 2048; a < 4096; a++)
			crc = fold(1'b0, crc, 8'(a) ^ 8'(a >> 8) ^ 8'h5A);
		acc(1, CRCAU_OFS_COUNT, 8'h01);
		acc(1, CRCAU_OFS_AUTO, 8'h82);
		acc(1, CRCAU_OFS_CONTROL, 8'h0C);
		idle();
		check(cpu_stall, 1'b1);
		n = 0;
		// Sampled at the falling edge, clear of the edge that moves stall.
		while (cpu_stall === 1'b1 && n < 6000) begin
			@(negedge clk_sys);
			n++;
		end
		check(n, 32'd4096);
		acc(0, CRCAU_OFS_AUTO, 8'h00);
		check(q, 8'hC2);
		rd_res(1'b0);
		acc(1, CRCAU_OFS_AUTO, 8'h00);
		idle();
		$display("scan done");
	endtask
	// A reset in mid-scan must drop the stall and restore the auto register.
	task automatic t_reset();
		acc(1, CRCAU_OFS_AUTO, 8'h81);
		acc(1, CRCAU_OFS_CONTROL, 8'h00);
		idle();
		check(cpu_stall, 1'b1);
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b0;
		#1 check(cpu_stall, 1'b0);
		@(negedge clk_sys);
		reset_n = 1'b1;
		acc(0, CRCAU_OFS_AUTO, 8'h00);
		check(q, 8'h40);
		idle();
		$display("reset done");
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		repeat (2) @(negedge clk_sys);
		reset_n = 1'b1;
		t_regs();
		t_feed();
		t_scan();
		t_reset();
		close_out();
	end
endmodule
`default_nettype wire
